// File: hw/psb_pkg.sv
package psb_pkg;
  // loopback datapath shape
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = 32;
  // dllp send command codes
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_PM = 2'h1;
  localparam logic [1:0] CMD_VENDOR = 2'h2;
  localparam logic [1:0] CMD_UNUSED = 2'h3;
  // power message types
  localparam logic [2:0] PM_ENTER_L1 = 3'h0;
  localparam logic [2:0] PM_ENTER_L2 = 3'h1;
  localparam logic [2:0] PM_ASPM_L1 = 3'h3;
  localparam logic [2:0] PM_REQ_ACK = 3'h4;
  // dllp framing toward the phy
  localparam logic [7:0] DLLP_PM_BASE = 8'h20;
  localparam logic [7:0] DLLP_VENDOR_TYPE = 8'h30;
  localparam int DLLP_BYTES = 4;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SENT = 4'h8;
  localparam int CTRL_LBK_EN = 0;
  localparam int CTRL_HOLD_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int STS_LBK_READY = 0;
  localparam int STS_HOLD_CFG = 1;
  localparam int STS_IN_L0 = 2;
  localparam int STS_LL_INACTIVE = 3;
  localparam int STS_LL_INIT = 4;
  localparam int STS_LL_ACTIVE = 5;
  localparam int STS_LL_UP = 6;
  localparam int STS_DLLP_BUSY = 7;
  localparam int STS_BAD_CMD = 8;
  localparam int STS_W = 9;
  localparam int SENT_W = 16;
  typedef enum logic [1:0] {LT_DETECT, LT_CFG_COMPLETE, LT_L0} psb_ltssm_t;
  typedef enum logic [1:0] {LL_INACTIVE, LL_INITIALIZING, LL_ACTIVE} psb_link_t;
  typedef enum logic {TX_IDLE, TX_SEND} psb_dtx_t;
endpackage

// File: hw/psb_lbk_path.sv
`timescale 1ns/1ns
`default_nettype none
module psb_lbk_path (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // loopback active
  input wire logic enable,
  // user transmit side
  input wire logic [psb_pkg::DATA_W-1:0] txData,
  input wire logic [psb_pkg::LANES-1:0] txK,
  // phy side
  output logic [psb_pkg::DATA_W-1:0] phyTxData_r,
  output logic [psb_pkg::LANES-1:0] phyTxK_r,
  input wire logic [psb_pkg::DATA_W-1:0] phyRxData,
  input wire logic [psb_pkg::LANES-1:0] phyRxK,
  // user receive side
  output logic [psb_pkg::DATA_W-1:0] rxData_r,
  output logic [psb_pkg::LANES-1:0] rxK_r
);
  import psb_pkg::*;

  logic [DATA_W-1:0] phyTxData_nxt, rxData_nxt;
  logic [LANES-1:0] phyTxK_nxt, rxK_nxt;

  // lane n owns byte n and flag bit n; a disabled path reads as zero
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      always_comb begin
        phyTxData_nxt[lane*LANE_W +: LANE_W] = enable ? txData[lane*LANE_W +: LANE_W] : 8'h00;
        phyTxK_nxt[lane] = enable & txK[lane];
        rxData_nxt[lane*LANE_W +: LANE_W] = enable ? phyRxData[lane*LANE_W +: LANE_W] : 8'h00;
        rxK_nxt[lane] = enable & phyRxK[lane];
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      phyTxData_r <= '0;
      phyTxK_r <= '0;
      rxData_r <= '0;
      rxK_r <= '0;
    end else begin
      phyTxData_r <= phyTxData_nxt;
      phyTxK_r <= phyTxK_nxt;
      rxData_r <= rxData_nxt;
      rxK_r <= rxK_nxt;
    end
  end

  a_rx_lane_map: assert property (@(posedge mclk) disable iff (rst)
    enable |=> rxData_r[31:24] == $past(phyRxData[31:24]) && rxData_r[7:0] == $past(phyRxData[7:0]))
    else $error("loopback receive lane order broken");
  a_rx_kflag_map: assert property (@(posedge mclk) disable iff (rst)
    enable |=> rxK_r == $past(phyRxK))
    else $error("loopback receive k flags wrong");
  a_lbk_gated: assert property (@(posedge mclk) disable iff (rst)
    !enable |=> rxK_r == 4'h0 && rxData_r == 32'h0 && phyTxK_r == 4'h0)
    else $error("loopback path active while disabled");
endmodule
`default_nettype wire

// File: hw/psb_dllp_tx.sv
`timescale 1ns/1ns
`default_nettype none
module psb_dllp_tx (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request from control, type byte in the top byte
  input wire logic start,
  input wire logic [psb_pkg::DATA_W-1:0] frame,
  output logic busy_r,
  output logic done_r,
  // byte stream toward the phy
  output logic [7:0] phyByte_r,
  output logic phyValid_r,
  input wire logic phyReady
);
  import psb_pkg::*;

  localparam logic [1:0] LAST_IDX = 2'(DLLP_BYTES - 1);
  psb_dtx_t state_r, state_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [DATA_W-1:0] frame_r, frame_nxt;
  logic [7:0] phyByte_nxt;
  logic phyValid_nxt, done_nxt;

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    frame_nxt = frame_r;
    phyByte_nxt = phyByte_r;
    phyValid_nxt = phyValid_r;
    done_nxt = 1'b0;
    unique case (state_r)
      TX_IDLE: begin
        if (start) begin
          state_nxt = TX_SEND;
          idx_nxt = 2'h0;
          frame_nxt = frame;
          phyByte_nxt = frame[31:24];
          phyValid_nxt = 1'b1;
        end
      end
      TX_SEND: begin
        // byte held until the phy takes it
        if (phyReady) begin
          if (idx_r == LAST_IDX) begin
            state_nxt = TX_IDLE;
            phyValid_nxt = 1'b0;
            done_nxt = 1'b1;
          end else begin
            idx_nxt = idx_r + 2'h1;
            frame_nxt = {frame_r[23:0], 8'h00};
            phyByte_nxt = frame_r[23:16];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= TX_IDLE;
      idx_r <= 2'h0;
      frame_r <= '0;
      phyByte_r <= 8'h00;
      phyValid_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      frame_r <= frame_nxt;
      phyByte_r <= phyByte_nxt;
      phyValid_r <= phyValid_nxt;
      done_r <= done_nxt;
      busy_r <= state_nxt == TX_SEND;
    end
  end

  a_stall_holds: assert property (@(posedge mclk) disable iff (rst)
    phyValid_r && !phyReady |=> phyValid_r && $stable(phyByte_r))
    else $error("dllp byte changed under stall");
  a_done_last: assert property (@(posedge mclk) disable iff (rst)
    done_r |-> $past(phyValid_r && phyReady && idx_r == LAST_IDX) && !phyValid_r)
    else $error("dllp done without last byte taken");
endmodule
`default_nettype wire

// File: hw/psb_sideband_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - receive k flag bit n marks a control character on received byte lane n
// - received word delivered with lane 3 top byte down to lane 0 bottom
// - loopback ports active only when loopback is built in, timed by the 250 MHz clock
// - training waits in configuration complete until programming done is high
// - the hold serves dynamic width and exists only on the variant having it
// - three indicators show link layer inactive, initializing or active
// - link up only while active and handing packets to the transaction layer
// - device pulses sent once the requested packet is transmitted
// - loopback ready tells user when transmit loopback data may be presented
// - a 250 MHz timing clock flag accompanies the loopback path when built in
module psb_sideband_top #(
  parameter bit HAS_MASTER_LBK = 1'b1,
  parameter bit HAS_PROG_DONE = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [psb_pkg::DATA_W-1:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [psb_pkg::DATA_W-1:0] avsReadData_r,
  output logic avsWaitrequest_r,
  // user loopback
  input wire logic [psb_pkg::DATA_W-1:0] txLbkData,
  input wire logic [psb_pkg::LANES-1:0] txLbkK,
  output logic txLbkReady_r,
  output logic lbkClkActive_r,
  output logic [psb_pkg::DATA_W-1:0] rxLbkData_r,
  output logic [psb_pkg::LANES-1:0] rxLbkK_r,
  // phy loopback
  input wire logic phyMasterLoopback,
  output logic [psb_pkg::DATA_W-1:0] phyLbkTxData_r,
  output logic [psb_pkg::LANES-1:0] phyLbkTxK_r,
  input wire logic [psb_pkg::DATA_W-1:0] phyLbkRxData,
  input wire logic [psb_pkg::LANES-1:0] phyLbkRxK,
  // link training
  input wire logic trainCfgComplete,
  input wire logic trainLinkDown,
  input wire logic progDone,
  output logic ltssmHoldCfg_r,
  output logic ltssmInL0_r,
  // data link layer
  input wire logic fcInitDone,
  input wire logic tlReady,
  output logic linkLayerInactive_r,
  output logic linkLayerInitializing_r,
  output logic linkLayerActive_r,
  output logic linkLayerUp_r,
  // dllp request
  input wire logic [1:0] dllpSendCmd,
  input wire logic [2:0] dllpPmType,
  input wire logic [23:0] dllpVendorData,
  output logic dllpSent_r,
  // dllp byte stream
  output logic [7:0] phyDllpByte_r,
  output logic phyDllpValid_r,
  input wire logic phyDllpReady
);
  import psb_pkg::*;

  logic [1:0] ctrl_r, ctrl_nxt;
  logic [DATA_W-1:0] rdData_nxt, readMux;
  logic wait_nxt, wrFire;
  logic [STS_W-1:0] status;
  logic badCmd_r, badCmd_nxt;
  logic [SENT_W-1:0] sent_r, sent_nxt;
  logic lbkEn, holdEn;
  psb_ltssm_t ltssm_r, ltssm_nxt;
  psb_link_t link_r, link_nxt;
  logic armed_r, armed_nxt, dllpSent_nxt;
  logic dtxStart, dtxBusy, dtxDone, cmdLegal;
  logic [DATA_W-1:0] dtxFrame;

  assign lbkEn = HAS_MASTER_LBK & ctrl_r[CTRL_LBK_EN];
  // without the input the hold cannot be released, so it is built out
  assign holdEn = HAS_PROG_DONE & ctrl_r[CTRL_HOLD_EN];

  // register bus: one wait state, answer always in the cycle after the request appears
  always_comb begin
    readMux = '0;
    unique case (avsAddress)
      REG_CTRL: readMux = {30'h0, ctrl_r};
      REG_STATUS: readMux = {23'h0, status};
      REG_SENT: readMux = {16'h0, sent_r};
      default: readMux = '0;
    endcase
  end

  always_comb begin
    wait_nxt = 1'b1;
    rdData_nxt = avsReadData_r;
    if ((avsRead || avsWrite) && avsWaitrequest_r) begin
      wait_nxt = 1'b0;
      if (avsRead) begin
        rdData_nxt = readMux;
      end
    end
  end

  assign wrFire = avsWrite && !avsWaitrequest_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wrFire && avsAddress == REG_CTRL && avsByteEnable[0]) begin
      ctrl_nxt = avsWriteData[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avsWaitrequest_r <= 1'b1;
      avsReadData_r <= '0;
      ctrl_r <= CTRL_RESET;
    end else begin
      avsWaitrequest_r <= wait_nxt;
      avsReadData_r <= rdData_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  always_comb begin
    status = '0;
    status[STS_LBK_READY] = txLbkReady_r;
    status[STS_HOLD_CFG] = ltssmHoldCfg_r;
    status[STS_IN_L0] = ltssmInL0_r;
    status[STS_LL_INACTIVE] = linkLayerInactive_r;
    status[STS_LL_INIT] = linkLayerInitializing_r;
    status[STS_LL_ACTIVE] = linkLayerActive_r;
    status[STS_LL_UP] = linkLayerUp_r;
    status[STS_DLLP_BUSY] = dtxBusy;
    status[STS_BAD_CMD] = badCmd_r;
  end

  // link training, held in configuration complete for the aligner
  always_comb begin
    ltssm_nxt = ltssm_r;
    if (trainLinkDown) begin
      ltssm_nxt = LT_DETECT;
    end else begin
      unique case (ltssm_r)
        LT_DETECT: if (trainCfgComplete) ltssm_nxt = LT_CFG_COMPLETE;
        LT_CFG_COMPLETE: if (!holdEn || progDone) ltssm_nxt = LT_L0;
        LT_L0: ltssm_nxt = LT_L0;
      endcase
    end
  end

  // link layer follows the physical link
  always_comb begin
    link_nxt = link_r;
    if (ltssm_r != LT_L0) begin
      link_nxt = LL_INACTIVE;
    end else begin
      unique case (link_r)
        LL_INACTIVE: link_nxt = LL_INITIALIZING;
        LL_INITIALIZING: if (fcInitDone) link_nxt = LL_ACTIVE;
        LL_ACTIVE: link_nxt = LL_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ltssm_r <= LT_DETECT;
      ltssmHoldCfg_r <= 1'b0;
      ltssmInL0_r <= 1'b0;
      link_r <= LL_INACTIVE;
      linkLayerInactive_r <= 1'b1;
      linkLayerInitializing_r <= 1'b0;
      linkLayerActive_r <= 1'b0;
      linkLayerUp_r <= 1'b0;
      txLbkReady_r <= 1'b0;
      lbkClkActive_r <= 1'b0;
    end else begin
      ltssm_r <= ltssm_nxt;
      ltssmHoldCfg_r <= ltssm_nxt == LT_CFG_COMPLETE;
      ltssmInL0_r <= ltssm_nxt == LT_L0;
      link_r <= link_nxt;
      linkLayerInactive_r <= link_nxt == LL_INACTIVE;
      linkLayerInitializing_r <= link_nxt == LL_INITIALIZING;
      linkLayerActive_r <= link_nxt == LL_ACTIVE;
      linkLayerUp_r <= link_nxt == LL_ACTIVE && tlReady;
      txLbkReady_r <= lbkEn && phyMasterLoopback;
      lbkClkActive_r <= lbkEn;
    end
  end

  // dllp requests; a fresh request needs one idle code after the last sent
  always_comb begin
    cmdLegal = 1'b0;
    unique case (dllpSendCmd)
      CMD_PM: cmdLegal = dllpPmType == PM_ENTER_L1 || dllpPmType == PM_ENTER_L2 ||
                         dllpPmType == PM_ASPM_L1 || dllpPmType == PM_REQ_ACK;
      CMD_VENDOR: cmdLegal = 1'b1;
      CMD_NONE, CMD_UNUSED: cmdLegal = 1'b0;
    endcase
  end

  assign dtxStart = armed_r && !dtxBusy && cmdLegal && link_r == LL_ACTIVE;
  assign dtxFrame = dllpSendCmd == CMD_VENDOR ? {DLLP_VENDOR_TYPE, dllpVendorData} :
                    {DLLP_PM_BASE | {5'h00, dllpPmType}, 24'h000000};

  always_comb begin
    armed_nxt = armed_r;
    if (dtxStart) begin
      armed_nxt = 1'b0;
    end else if (dllpSendCmd == CMD_NONE && !dtxBusy) begin
      armed_nxt = 1'b1;
    end
    badCmd_nxt = badCmd_r;
    if (wrFire && avsAddress == REG_STATUS && avsByteEnable[1] && avsWriteData[STS_BAD_CMD]) begin
      badCmd_nxt = 1'b0;
    end
    // set after clear so a new fault in the clear cycle survives
    if (armed_r && !dtxBusy && dllpSendCmd != CMD_NONE && !cmdLegal) begin
      badCmd_nxt = 1'b1;
    end
    dllpSent_nxt = dtxDone;
    sent_nxt = dtxDone ? sent_r + 1'b1 : sent_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      armed_r <= 1'b1;
      badCmd_r <= 1'b0;
      dllpSent_r <= 1'b0;
      sent_r <= '0;
    end else begin
      armed_r <= armed_nxt;
      badCmd_r <= badCmd_nxt;
      dllpSent_r <= dllpSent_nxt;
      sent_r <= sent_nxt;
    end
  end

  psb_lbk_path u_lbk (
    .mclk(mclk),
    .rst(rst),
    .enable(lbkEn),
    .txData(txLbkData),
    .txK(txLbkK),
    .phyTxData_r(phyLbkTxData_r),
    .phyTxK_r(phyLbkTxK_r),
    .phyRxData(phyLbkRxData),
    .phyRxK(phyLbkRxK),
    .rxData_r(rxLbkData_r),
    .rxK_r(rxLbkK_r)
  );

  psb_dllp_tx u_dtx (
    .mclk(mclk),
    .rst(rst),
    .start(dtxStart),
    .frame(dtxFrame),
    .busy_r(dtxBusy),
    .done_r(dtxDone),
    .phyByte_r(phyDllpByte_r),
    .phyValid_r(phyDllpValid_r),
    .phyReady(phyDllpReady)
  );

  sequence s_held;
    ltssm_r == LT_CFG_COMPLETE && holdEn;
  endsequence
  sequence s_release;
    progDone && !trainLinkDown;
  endsequence

  a_cfg_hold: assert property (@(posedge mclk) disable iff (rst)
    s_held ##0 (!progDone && !trainLinkDown) |=> ltssmHoldCfg_r && !ltssmInL0_r)
    else $error("left configuration complete without programming done");
  a_prog_release: assert property (@(posedge mclk) disable iff (rst)
    s_held ##0 s_release |=> ltssmInL0_r ##1 (linkLayerInitializing_r || trainLinkDown))
    else $error("programming done did not release to L0");
  a_ind_onehot: assert property (@(posedge mclk) disable iff (rst)
    $onehot({linkLayerInactive_r, linkLayerInitializing_r, linkLayerActive_r}))
    else $error("link layer indicators not one-hot");
  a_up_active: assert property (@(posedge mclk) disable iff (rst)
    linkLayerUp_r |-> linkLayerActive_r && $past(tlReady))
    else $error("link up without active layer");
  a_sent_pulse: assert property (@(posedge mclk) disable iff (rst)
    dllpSent_r |=> !dllpSent_r)
    else $error("sent is not a single pulse");
  a_request_sent: assert property (@(posedge mclk) disable iff (rst)
    dtxStart && phyDllpReady [*1] ##1 phyDllpReady [*4] |=> ##[0:1] dllpSent_r)
    else $error("dllp not reported sent");
  a_ready_cause: assert property (@(posedge mclk) disable iff (rst)
    txLbkReady_r |-> $past(lbkEn && phyMasterLoopback))
    else $error("loopback ready without loopback");
  a_clk_flag: assert property (@(posedge mclk) disable iff (rst)
    lbkClkActive_r == $past(lbkEn) || $past(rst))
    else $error("loopback clock flag mismatch");
  a_cmd_refused: assert property (@(posedge mclk) disable iff (rst)
    dllpSendCmd == CMD_UNUSED && armed_r && !dtxBusy |=> !dtxBusy && badCmd_r)
    else $error("unused send code not refused");
  a_bus_answer: assert property (@(posedge mclk) disable iff (rst)
    (avsRead || avsWrite) && avsWaitrequest_r |=> !avsWaitrequest_r)
    else $error("bus request not answered");
endmodule
`default_nettype wire

// File: bench/psb_user_model.sv
`timescale 1ns/1ns
`default_nettype none
module psb_user_model #(
  parameter int PROG_DLY = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic abort,
  input wire logic [1:0] cmdIn,
  input wire logic [2:0] typeIn,
  input wire logic [23:0] dataIn,
  // dllp request toward the device
  output logic [1:0] dllpSendCmd,
  output logic [2:0] dllpPmType,
  output logic [23:0] dllpVendorData,
  input wire logic sent,
  // aligner handshake
  input wire logic holdCfg,
  output logic progDone
);
  import psb_pkg::*;
  int alignCnt;
  always @(posedge mclk) begin
    if (rst) begin
      dllpSendCmd <= CMD_NONE;
      dllpPmType <= 3'h0;
      dllpVendorData <= 24'h0;
    end else if (go) begin
      // code and arguments launched together
      dllpSendCmd <= cmdIn;
      dllpPmType <= typeIn;
      dllpVendorData <= dataIn;
    end else if (sent || abort) begin
      // stale arguments scrambled so the device cannot lean on them
      dllpSendCmd <= CMD_NONE;
      dllpPmType <= ~dllpPmType;
      dllpVendorData <= ~dllpVendorData;
    end
  end
  // aligner programming takes a while once the width is known
  always @(posedge mclk) begin
    if (rst) begin
      alignCnt <= 0;
      progDone <= 1'b0;
    end else if (holdCfg && alignCnt < PROG_DLY) begin
      alignCnt <= alignCnt + 1;
    end else if (alignCnt == PROG_DLY) begin
      progDone <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: bench/psb_sideband_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module psb_sideband_top_tb;
  import psb_pkg::*;
  typedef struct {
    logic [31:0] tD;
    logic [3:0] tK;
    logic [31:0] rD;
    logic [3:0] rK;
  } psb_row_t;
  logic mclk = 1'b0;
  logic rst;
  logic [3:0] avsAddress, avsByteEnable, txLbkK, phyLbkRxK, rxLbkK_r, phyLbkTxK_r;
  logic avsRead, avsWrite, avsWaitrequest_r, txLbkReady_r, lbkClkActive_r, phyMasterLoopback;
  logic [31:0] avsWriteData, avsReadData_r, txLbkData, rxLbkData_r, phyLbkTxData_r, phyLbkRxData, rd;
  logic trainCfgComplete, trainLinkDown, progDone, ltssmHoldCfg_r, ltssmInL0_r, fcInitDone, tlReady;
  logic linkLayerInactive_r, linkLayerInitializing_r, linkLayerActive_r, linkLayerUp_r;
  logic [1:0] dllpSendCmd, cmdIn;
  logic [2:0] dllpPmType, typeIn;
  logic [23:0] dllpVendorData, dataIn;
  logic dllpSent_r, phyDllpValid_r, phyDllpReady, go, abort, stall;
  logic [7:0] phyDllpByte_r;
  logic [7:0] got[$];
  int error_cnt = 0;
  int cmp_count = 0;
  psb_row_t rows[4] = '{
    '{32'h11223344, 4'h0, 32'hA1B2C3D4, 4'h0},
    '{32'hBC000000, 4'h8, 32'h000000BC, 4'h1},
    '{32'h00BC0000, 4'h4, 32'h0000BC00, 4'h2},
    '{32'hBCBCBCBC, 4'hF, 32'hFEFD1C00, 4'hA}
  };
  logic [2:0] pmTypes[4] = '{PM_ENTER_L1, PM_ENTER_L2, PM_ASPM_L1, PM_REQ_ACK};

  always #2 mclk = ~mclk;

  psb_sideband_top u_dut (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData_r(avsReadData_r), .avsWaitrequest_r(avsWaitrequest_r), .txLbkData(txLbkData),
    .txLbkK(txLbkK), .txLbkReady_r(txLbkReady_r), .lbkClkActive_r(lbkClkActive_r),
    .rxLbkData_r(rxLbkData_r), .rxLbkK_r(rxLbkK_r), .phyMasterLoopback(phyMasterLoopback),
    .phyLbkTxData_r(phyLbkTxData_r), .phyLbkTxK_r(phyLbkTxK_r), .phyLbkRxData(phyLbkRxData),
    .phyLbkRxK(phyLbkRxK), .trainCfgComplete(trainCfgComplete), .trainLinkDown(trainLinkDown),
    .progDone(progDone), .ltssmHoldCfg_r(ltssmHoldCfg_r), .ltssmInL0_r(ltssmInL0_r),
    .fcInitDone(fcInitDone), .tlReady(tlReady), .linkLayerInactive_r(linkLayerInactive_r),
    .linkLayerInitializing_r(linkLayerInitializing_r), .linkLayerActive_r(linkLayerActive_r),
    .linkLayerUp_r(linkLayerUp_r), .dllpSendCmd(dllpSendCmd), .dllpPmType(dllpPmType),
    .dllpVendorData(dllpVendorData), .dllpSent_r(dllpSent_r), .phyDllpByte_r(phyDllpByte_r),
    .phyDllpValid_r(phyDllpValid_r), .phyDllpReady(phyDllpReady));

  psb_user_model u_user (.mclk(mclk), .rst(rst), .go(go), .abort(abort), .cmdIn(cmdIn),
    .typeIn(typeIn), .dataIn(dataIn), .dllpSendCmd(dllpSendCmd), .dllpPmType(dllpPmType),
    .dllpVendorData(dllpVendorData), .sent(dllpSent_r), .holdCfg(ltssmHoldCfg_r), .progDone(progDone));

  // byte stream sink; stalls every other cycle when asked
  always @(posedge mclk) begin
    if (phyDllpValid_r && phyDllpReady) got.push_back(phyDllpByte_r);
    phyDllpReady <= stall ? ~phyDllpReady : 1'b1;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic miss(input string m);
    error_cnt++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) miss(m);
  endtask

  // bounded wait; sees values as sampled at each edge
  task automatic waitHi(ref logic s);
    for (int n = 0; n < 60 && s !== 1'b1; n++) @(posedge mclk);
    if (s !== 1'b1) begin
      miss("timeout");
      end_sim();
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (avsWaitrequest_r === 1'b0) break;
    end
    if (n == 20) begin
      miss("bus timeout");
      end_sim();
    end
    rd = avsReadData_r;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // one idle edge so a following call never reassigns the strobes in this time step
    @(posedge mclk);
  endtask

  task automatic send(input logic [1:0] c, input logic [2:0] t, input logic [23:0] d, input logic [31:0] e);
    got.delete();
    cmdIn <= c;
    typeIn <= t;
    dataIn <= d;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    waitHi(dllpSent_r);
    chk(got.size(), DLLP_BYTES, "dllp byte count");
    chk({got[0], got[1], got[2], got[3]}, e, "dllp bytes");
    @(posedge mclk);
    chk(dllpSent_r, 1'b0, "sent pulse too long");
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    rst = 1'b1;
    {avsAddress, avsRead, avsWrite, avsWriteData} = '0;
    avsByteEnable = 4'hF;
    {txLbkData, txLbkK, phyMasterLoopback, phyLbkRxData, phyLbkRxK} = '0;
    {trainCfgComplete, trainLinkDown, fcInitDone, tlReady} = '0;
    {go, abort, cmdIn, typeIn, dataIn, stall} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(linkLayerInactive_r, 1'b1, "inactive after reset");
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h2, "ctrl reset value");
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, REG_CTRL, 32'h3);
    phyMasterLoopback <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(txLbkReady_r, 1'b1, "loopback ready");
    chk(lbkClkActive_r, 1'b1, "loopback clock flag");
    foreach (rows[i]) begin
      txLbkData <= rows[i].tD;
      txLbkK <= rows[i].tK;
      phyLbkRxData <= rows[i].rD;
      phyLbkRxK <= rows[i].rK;
      repeat (2) @(posedge mclk);
      chk(phyLbkTxData_r, rows[i].tD, "tx lanes");
      chk(phyLbkTxK_r, rows[i].tK, "tx flags");
      chk(rxLbkData_r, rows[i].rD, "rx lanes");
      chk(rxLbkK_r, rows[i].rK, "rx flags");
    end
    // loopback switched off: outputs must fall silent
    bus(1'b1, REG_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    chk(rxLbkData_r, 32'h0, "rx data while off");
    chk(phyLbkTxK_r, 4'h0, "tx flags while off");
    chk(txLbkReady_r, 1'b0, "ready while off");
    chk(lbkClkActive_r, 1'b0, "clock flag while off");
    trainCfgComplete <= 1'b1;
    waitHi(ltssmHoldCfg_r);
    repeat (2) @(posedge mclk);
    chk(ltssmInL0_r, 1'b0, "left cfg before done");
    waitHi(ltssmInL0_r);
    chk(progDone, 1'b1, "l0 without done");
    chk(ltssmHoldCfg_r, 1'b0, "hold stayed in l0");
    waitHi(linkLayerInitializing_r);
    chk({linkLayerInactive_r, linkLayerActive_r, linkLayerUp_r}, 3'h0, "init one-hot");
    fcInitDone <= 1'b1;
    waitHi(linkLayerActive_r);
    chk({linkLayerInitializing_r, linkLayerUp_r}, 2'h0, "up before tl ready");
    tlReady <= 1'b1;
    waitHi(linkLayerUp_r);
    foreach (pmTypes[i]) send(CMD_PM, pmTypes[i], 24'h0, {DLLP_PM_BASE | pmTypes[i], 24'h0});
    stall <= 1'b1;
    send(CMD_VENDOR, 3'h0, 24'hA5C3E1, {DLLP_VENDOR_TYPE, 24'hA5C3E1});
    stall <= 1'b0;
    bus(1'b0, REG_SENT, 32'h0);
    chk(rd, 32'h5, "sent count");
    for (int i = 0; i < 2; i++) begin
      got.delete();
      cmdIn <= i ? CMD_PM : CMD_UNUSED;
      typeIn <= i ? 3'h7 : 3'h0;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (12) @(posedge mclk);
      chk(got.size(), 0, "refused command sent");
      abort <= 1'b1;
      @(posedge mclk);
      abort <= 1'b0;
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[STS_BAD_CMD], 1'b1, "bad command flag");
      bus(1'b1, REG_STATUS, 32'h100);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rd[STS_BAD_CMD], 1'b0, "bad command clear");
    end
    trainLinkDown <= 1'b1;
    waitHi(linkLayerInactive_r);
    chk({linkLayerUp_r, linkLayerActive_r, ltssmInL0_r}, 3'h0, "link down");
    // second reset, then training with the hold off must not wait for programming done
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h2, "ctrl after second reset");
    bus(1'b1, REG_CTRL, 32'h0);
    trainLinkDown <= 1'b0;
    waitHi(ltssmInL0_r);
    chk(progDone, 1'b0, "hold off still waited for done");
    end_sim();
  end
endmodule
`default_nettype wire
